// ==== hdl/pcith_pkg.sv ====
/*
 Package for the PCI target/initiator handshake block: reset and timing
 constants, the state encoding and the packed structs carried between
 the handshake logic and the bridge core.
 Assumes a single 125 MHz clock and active-low PCI control pins.
*/
package pcith_pkg;

    localparam int  CLOCK_MHZ            = 125;
    // Least PCI reset pulse for a software hard reset, in microseconds
    localparam int  BUS_RESET_US         = 1000;
    localparam int  BUS_RESET_CYCLES     = BUS_RESET_US * CLOCK_MHZ;
    localparam int  STATE_WIDTH          = 2;

    typedef enum logic [1:0] {
        PCITH_IDLE      = 2'b00,
        PCITH_TARGET    = 2'b01,
        PCITH_INITIATOR = 2'b10,
        PCITH_TURN      = 2'b11
    } pcith_state_t;

    // One tri-state PCI control pin as seen by the design
    typedef struct packed {
        logic out_n;
        logic oe;
    } pcith_pin_t;

    // Requests from the bridge core
    typedef struct packed {
        logic claim;        // Address decoded as ours, take the target role
        logic target_ready; // Read data on the data lines or ready to capture write data
        logic target_stop;  // Core wants the initiator to stop
        logic master_start; // Begin an initiator transaction
        logic master_ready; // Write data valid or ready to capture read data
        logic master_last;  // Current data phase is the last one
    } pcith_req_t;

    // Status back to the bridge core
    typedef struct packed {
        logic data_done;    // Data phase completed this edge
        logic stopped;      // Initiator transaction ended by target stop
        logic is_target;
        logic is_initiator;
    } pcith_stat_t;

    localparam logic RESET_OE  = 1'b0;
    localparam logic RESET_OUT = 1'b1;

endpackage

// ==== hdl/pcith_top.sv ====
/*
 PCI control handshake of a PCI-to-ISA bridge: drives target ready and stop
 as target, initiator ready as initiator, samples the partner's strobes,
 turns a system error into an NMI and generates the PCI bus reset.
 Assumes all pin inputs are synchronous to clock and the bus level is resolved
 outside from the output enables; frame and address phase are handled by the core.
*/
// How it works
// R1 - Any PCI agent may pulse the system error line on detecting an error.
// R2 - Sampled system error raises NMI when the enable input is set.
// R3 - As target, assert stop to ask the initiator to end the transaction.
// R4 - As initiator, end the current transaction when stop is sampled asserted.
// R5 - Drive stop only as target; treat it as input as initiator.
// R6 - PCI reset floats stop and target ready until next target response.
// R7 - Data phase completes only when both ready lines sampled asserted.
// R8 - On target reads, assert target ready only with valid read data present.
// R9 - On target writes, assert target ready only when able to capture data.
// R10 - Drive target ready as target; sample it as input as initiator.
// R11 - As initiator, assert initiator ready when data valid or ready to capture.
// R12 - Assert PCI reset at power-up and on a software hard reset request.
// R13 - Drive target ready and stop only during claimed accesses, then release.
`timescale 1ns/1ps
`default_nettype none
module pcith_top #(
    parameter int RESET_CYCLES = pcith_pkg::BUS_RESET_CYCLES
) (
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    input  wire logic                   hard_reset_request,
    input  wire logic                   nmi_on_serr_enable,
    input  wire pcith_pkg::pcith_req_t  req,
    input  wire logic                   trdy_in_n,
    input  wire logic                   irdy_in_n,
    input  wire logic                   stop_in_n,
    input  wire logic                   serr_in_n,
    output pcith_pkg::pcith_pin_t       trdy_pin,
    output pcith_pkg::pcith_pin_t       stop_pin,
    output pcith_pkg::pcith_pin_t       irdy_pin,
    output pcith_pkg::pcith_stat_t      stat,
    output logic                        nmi,
    output logic                        pci_reset_n
);

    // Elaboration-time refusal of a bus reset pulse the counter cannot time
    if (RESET_CYCLES < 1) begin : g_bad_reset_cycles
        $error("RESET_CYCLES must be at least one");
    end

    localparam int CW = $clog2(RESET_CYCLES + 1);

    logic                    rst_meta_n;
    logic                    rst_sync_n;
    logic [CW-1:0]           reset_count;
    logic                    bus_reset;
    pcith_pkg::pcith_state_t state;
    pcith_pkg::pcith_state_t next_state;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // Bus reset held from power-up, restarted by software for the full pulse
    wire count_done = (reset_count == CW'(RESET_CYCLES));
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reset_count <= '0;
        end else if (hard_reset_request) begin
            reset_count <= '0; // R12
        end else if (!count_done) begin
            reset_count <= reset_count + CW'(1);
        end
    end
    assign bus_reset = !count_done; // R12

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pci_reset_n <= 1'b0;
        end else begin
            pci_reset_n <= count_done; // R12
        end
    end

    // Handshake sampling on the current edge
    wire data_done = !trdy_in_n && !irdy_in_n;          // R7
    wire stop_seen = !stop_in_n;                        // R4
    wire in_target = (state == pcith_pkg::PCITH_TARGET);
    wire in_master = (state == pcith_pkg::PCITH_INITIATOR);
    wire master_end = in_master && (stop_seen || (data_done && req.master_last)); // R4
    wire target_end = in_target && data_done && req.target_stop;

    always_comb begin
        next_state = state;
        case (state)
            pcith_pkg::PCITH_IDLE: begin
                if (req.claim) begin
                    next_state = pcith_pkg::PCITH_TARGET; // R13
                end else if (req.master_start) begin
                    next_state = pcith_pkg::PCITH_INITIATOR;
                end
            end
            pcith_pkg::PCITH_TARGET: begin
                if (target_end || (req.target_stop && irdy_in_n && !req.target_ready)) begin
                    next_state = pcith_pkg::PCITH_TURN; // R13
                end
            end
            pcith_pkg::PCITH_INITIATOR: begin
                if (master_end) begin
                    next_state = pcith_pkg::PCITH_TURN;
                end
            end
            pcith_pkg::PCITH_TURN: begin
                next_state = pcith_pkg::PCITH_IDLE;
            end
            default: begin
                next_state = pcith_pkg::PCITH_IDLE;
            end
        endcase
        // No role is taken while the bus is in reset, so no strobe leaks out; data_done and stopped still follow the old state on its first edge
        if (bus_reset) begin
            next_state = pcith_pkg::PCITH_IDLE; // R6
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state <= pcith_pkg::PCITH_IDLE;
        end else if (bus_reset) begin
            state <= pcith_pkg::PCITH_IDLE; // R6
        end else begin
            state <= next_state;
        end
    end

    // Target strobes: driven only in the claimed target role
    wire drive_target = !bus_reset && (next_state == pcith_pkg::PCITH_TARGET ||
                        (in_target && next_state == pcith_pkg::PCITH_TURN));
    wire drive_master = !bus_reset && (next_state == pcith_pkg::PCITH_INITIATOR);
    wire assert_trdy  = (next_state == pcith_pkg::PCITH_TARGET) && req.target_ready; // R8 R9
    wire assert_stop  = (next_state == pcith_pkg::PCITH_TARGET) && req.target_stop;  // R3
    wire assert_irdy  = drive_master && req.master_ready;                            // R11

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            trdy_pin <= '{out_n: pcith_pkg::RESET_OUT, oe: pcith_pkg::RESET_OE};
            stop_pin <= '{out_n: pcith_pkg::RESET_OUT, oe: pcith_pkg::RESET_OE};
            irdy_pin <= '{out_n: pcith_pkg::RESET_OUT, oe: pcith_pkg::RESET_OE};
        end else begin
            trdy_pin <= '{out_n: !assert_trdy, oe: drive_target}; // R6 R10 R13
            stop_pin <= '{out_n: !assert_stop, oe: drive_target}; // R5 R6 R13
            irdy_pin <= '{out_n: !assert_irdy, oe: drive_master};
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            stat <= '0;
            nmi  <= 1'b0;
        end else begin
            stat <= '{data_done:    (in_target || in_master) && data_done, // R7
                      stopped:      in_master && stop_seen,                // R4
                      is_target:    (next_state == pcith_pkg::PCITH_TARGET),
                      is_initiator: (next_state == pcith_pkg::PCITH_INITIATOR)};
            nmi  <= nmi_on_serr_enable && !serr_in_n;                      // R1 R2
        end
    end

endmodule
`default_nettype wire

// ==== sim/pcith_properties.sv ====
/*
 Checker for pcith_top: pin roles, ready and stop causes, error and bus reset.
 Assumes it is bound to pcith_top and sees the resolved bus levels.
*/
`timescale 1ns/1ps
`default_nettype none
module pcith_properties (
    input wire logic                   clock,
    input wire logic                   rst_n,
    input wire logic                   hard_reset_request,
    input wire logic                   nmi_on_serr_enable,
    input wire pcith_pkg::pcith_req_t  req,
    input wire logic                   trdy_in_n,
    input wire logic                   irdy_in_n,
    input wire logic                   serr_in_n,
    input wire pcith_pkg::pcith_pin_t  trdy_pin,
    input wire pcith_pkg::pcith_pin_t  stop_pin,
    input wire pcith_pkg::pcith_pin_t  irdy_pin,
    input wire pcith_pkg::pcith_stat_t stat,
    input wire logic                   nmi,
    input wire logic                   pci_reset_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_nmi_follows: assert property (pci_reset_n |=> nmi == $past(!serr_in_n && nmi_on_serr_enable))
        else $error("nmi wrong");
    a_stop_role: assert property (stop_pin.oe |-> !stat.is_initiator && !irdy_pin.oe)
        else $error("stop driven as initiator");
    a_reset_float: assert property (!pci_reset_n |-> !trdy_pin.oe && !stop_pin.oe)
        else $error("pins driven in bus reset");
    a_done_both: assert property (stat.data_done |-> $past(!trdy_in_n && !irdy_in_n))
        else $error("done without both ready");
    a_trdy_cause: assert property (!trdy_pin.out_n |-> trdy_pin.oe && $past(req.target_ready))
        else $error("target ready without cause");
    a_stop_cause: assert property (!stop_pin.out_n |-> stop_pin.oe && $past(req.target_stop))
        else $error("stop without cause");
    a_irdy_cause: assert property (!irdy_pin.out_n |-> irdy_pin.oe && $past(req.master_ready))
        else $error("initiator ready without cause");
    a_claim_drive: assert property (pci_reset_n && $past(pci_reset_n) && req.claim && !stat.is_target
        && !stat.is_initiator && !trdy_pin.oe && !irdy_pin.oe |=> trdy_pin.oe && stop_pin.oe)
        else $error("claim not answered");
    a_bus_reset: assert property (hard_reset_request |-> ##2 !pci_reset_n)
        else $error("bus reset missing");
endmodule
`default_nettype wire

// ==== sim/pcith_partner.sv ====
/*
 Far-side PCI agent: initiator facing our target, target facing our
 initiator, and a system error source. Assumes pull-ups on released lines.
*/
`timescale 1ns/1ps
`default_nettype none
module pcith_partner (
    input  wire logic                  clock,
    input  wire pcith_pkg::pcith_pin_t trdy_pin,
    input  wire pcith_pkg::pcith_pin_t stop_pin,
    input  wire pcith_pkg::pcith_pin_t irdy_pin,
    input  wire logic                  slow,
    input  wire logic                  stop_ask,
    input  wire logic                  serr,
    output wire logic                  trdy_in_n,
    output wire logic                  irdy_in_n,
    output wire logic                  stop_in_n,
    output wire logic                  serr_in_n
);
    logic [1:0] wait_cnt = 2'h0;
    wire        go = !slow || wait_cnt == 2'h3;
    // Slow mode waits three cycles before answering
    always @(posedge clock) wait_cnt <= (trdy_pin.oe || irdy_pin.oe) ? wait_cnt + {1'b0, !go} : 2'h0;
    assign irdy_in_n = irdy_pin.oe ? irdy_pin.out_n : !(trdy_pin.oe && go);
    assign trdy_in_n = trdy_pin.oe ? trdy_pin.out_n : !(irdy_pin.oe && go && !stop_ask);
    assign stop_in_n = stop_pin.oe ? stop_pin.out_n : !(irdy_pin.oe && stop_ask);
    assign serr_in_n = !serr;
endmodule
`default_nettype wire

// ==== sim/pcith_top_test.sv ====
/*
 Bench for pcith_top: target, initiator, error and bus reset cases.
 Assumes pcith_partner resolves the shared control lines.
*/
`timescale 1ns/1ps
`default_nettype none
module pcith_top_test;
    localparam int RC = 8;
    logic clock = 1'b0, rst_n = 1'b0, hard_reset_request = 1'b0, nmi_on_serr_enable = 1'b0;
    logic slow = 1'b0, stop_ask = 1'b0, serr = 1'b0, nmi, pci_reset_n;
    logic trdy_in_n, irdy_in_n, stop_in_n, serr_in_n;
    pcith_pkg::pcith_req_t  req = '0;
    pcith_pkg::pcith_pin_t  trdy_pin, stop_pin, irdy_pin;
    pcith_pkg::pcith_stat_t stat;
    int fails = 0, checked = 0, n;
    always #4 clock = !clock;
    pcith_top #(.RESET_CYCLES(RC)) pcith_top_i (.*);
    pcith_partner pcith_partner_i (.*);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tgt(input logic rdy, input logic sl);
        @(posedge clock) begin slow <= sl; req <= {1'b1, rdy, 1'b1, 3'h0}; end
        @(posedge clock);
        @(negedge clock) chk({trdy_pin, stop_pin}, {!rdy, 3'h5});
        for (n = 0; n < 12 && stat.is_target === 1'b1; n++) @(negedge clock);
        chk(stat.data_done, rdy);
        @(posedge clock) req <= '0;
        repeat (2) @(negedge clock);
        chk({trdy_pin.oe, stop_pin.oe}, 2'h0);
    endtask
    task automatic mst(input logic stp);
        @(posedge clock) begin stop_ask <= stp; req <= 6'h07; end
        @(posedge clock);
        @(negedge clock) chk({irdy_pin, trdy_pin.oe, stop_pin.oe}, 4'h4);
        for (n = 0; n < 12 && stat.is_initiator === 1'b1; n++) @(negedge clock);
        chk({stat.data_done, stat.stopped}, {!stp, stp});
        @(posedge clock) req <= '0;
        repeat (2) @(negedge clock);
    endtask
    task automatic err;
        for (int e = 0; e < 2; e++) begin
            @(posedge clock) begin nmi_on_serr_enable <= e[0]; serr <= 1'b1; end
            @(posedge clock) serr <= 1'b0;
            @(negedge clock) chk(nmi, e[0]);
            @(negedge clock) chk(nmi, 1'b0);
        end
    endtask
    task automatic bus_rst;
        @(posedge clock) hard_reset_request <= 1'b1;
        @(posedge clock) hard_reset_request <= 1'b0;
        for (n = 0; n < 4 && pci_reset_n === 1'b1; n++) @(negedge clock);
        chk(pci_reset_n, 1'b0);
        @(posedge clock) req <= 6'h38;
        @(posedge clock) req <= '0;
        for (n = 2; n < 40 && pci_reset_n !== 1'b1; n++) @(negedge clock) chk({trdy_pin.oe, stop_pin.oe}, 2'h0);
        chk(n >= RC, 1'b1);
    endtask
    task automatic test_done;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        for (n = 0; n < 40 && pci_reset_n !== 1'b1; n++) @(negedge clock);
        chk(pci_reset_n, 1'b1);
        tgt(1'b1, 1'b0);
        tgt(1'b1, 1'b1);
        tgt(1'b0, 1'b1);
        mst(1'b0);
        mst(1'b1);
        err;
        bus_rst;
        tgt(1'b1, 1'b0);
        test_done;
    end
    initial begin
        #20000;
        fails++;
        test_done;
    end
endmodule
bind pcith_top pcith_properties pcith_properties_i (.*);
`default_nettype wire
